/* logic/uart_fifo.sv */
`timescale 1ns/1ps
module uart_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH),
	parameter int CW = AW + 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	input wire logic pop,
	output logic [WIDTH-1:0] pop_data,
	output logic [CW-1:0] count
);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic do_push;
	logic do_pop;

	assign do_push = push && (count != CW'(DEPTH));
	assign do_pop = pop && (count != '0);
	assign pop_data = mem_reg[rd_reg];

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_reg[wr_reg] <= push_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			count <= '0;
		end else if (clear) begin
			wr_reg <= '0;
			rd_reg <= '0;
			count <= '0;
		end else begin
			if (do_push) begin
				wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + AW'(1);
			end
			if (do_pop) begin
				rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + AW'(1);
			end
			if (do_push && !do_pop) begin
				count <= count + CW'(1);
			end else if (do_pop && !do_push) begin
				count <= count - CW'(1);
			end
		end
	end
endmodule // uart_fifo

/* logic/uart_map.svh */
`ifndef UART_MAP_SVH
`define UART_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_DATA 8'h00
`define OFS_IER 8'h04
`define OFS_IIR 8'h08
`define OFS_LCR 8'h0C
`define OFS_MCR 8'h10
`define OFS_LSR 8'h14
`define OFS_USR 8'h7C
`define OFS_CLKG 8'h80

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCR_DIVISOR_LATCH_ACCESS_BIT 7
`define LCR_BREAK 6
`define LCR_EPS 4
`define LCR_PEN 3
`define LCR_STOP 2
`define IER_PROG_TX_EMPTY_MODE_BIT 7
`define IER_RLS 2
`define IER_TX_HOLDING_EMPTY 1
`define IER_RDA 0
`define FCR_EN 0
`define FCR_RXRST 1
`define FCR_TXRST 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCR_RESET 8'h03
`define IER_RESET 8'h00
`define FCR_RESET 8'h00
`define MCR_RESET 5'h00
`define DIV_RESET 8'h00
`define CLKG_RESET 1'b0

// ----------------------------------------
// Timing counts in baud ticks
// ----------------------------------------
`define BIT_TICKS 5'd16
`define HALF_TICKS 5'd8
`define MID_TICK 5'd7

// ----------------------------------------
// Interrupt identity codes
// ----------------------------------------
`define IIR_NONE 4'h1
`define IIR_TX_HOLDING_EMPTY 4'h2
`define IIR_RDA 4'h4
`define IIR_RLS 4'h6
`endif

/* logic/uart_pkg.sv */
package uart_pkg;
	typedef enum logic [4:0] {
		TX_IDLE = 5'b0_0001,
		TX_START = 5'b0_0010,
		TX_DATA = 5'b0_0100,
		TX_PARITY = 5'b0_1000,
		TX_STOP = 5'b1_0000
	} tx_state_type;
	typedef enum logic [4:0] {
		RX_IDLE = 5'b0_0001,
		RX_START = 5'b0_0010,
		RX_DATA = 5'b0_0100,
		RX_PARITY = 5'b0_1000,
		RX_STOP = 5'b1_0000
	} rx_state_type;
endpackage

/* logic/uart_top.sv */
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "uart_map.svh"
module uart_top #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd,
	output logic txd,
	output logic irq,
	output logic sys_clk_en,
	output logic serial_clk_en
);
	localparam int CW = $clog2(FIFO_DEPTH) + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
	localparam logic [CW-1:0] TET_2 = CW'(2);
	localparam logic [CW-1:0] LVL_QUARTER = CW'(FIFO_DEPTH / 4);
	localparam logic [CW-1:0] LVL_HALF = CW'(FIFO_DEPTH / 2);
	localparam logic [CW-1:0] LVL_NEAR_FULL = CW'(FIFO_DEPTH - 2);

	// ----------------------------------------
	// Registers and bus decode
	// ----------------------------------------
	logic [7:0] line_control_reg;
	logic [7:0] interrupt_enable_reg;
	logic [7:0] fifo_control_reg;
	logic [4:0] modem_control_reg;
	logic [7:0] divisor_low_reg;
	logic [7:0] divisor_high_reg;
	logic clock_gate_reg;
	logic oe_reg, pe_reg, fe_reg, bi_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic txd_reg;
	logic irq_reg;

	logic wr_acc, rd_acc, divisor_latch_access_bit, fifo_en, prog_tx_empty_mode_bit_active;
	logic [15:0] divisor;
	logic tx_push, tx_pop, rx_push, rx_pop, tx_clear, rx_clear, lsr_read;
	logic [7:0] tx_head, rx_head, rx_word;
	logic [CW-1:0] tx_count, rx_count;
	logic tx_empty, tx_full, rx_empty, rx_full;
	logic tx_holding_empty, rx_avail, tx_holding_empty_cond, lsi;
	logic [3:0] iir_id;
	logic [7:0] line_status_reg, interrupt_ident_reg;
	logic [31:0] rdata_c;
	logic hit_c;
	logic busy;
	logic [CW-1:0] tx_empty_trigger, rx_trigger_level;

	assign divisor = {divisor_high_reg, divisor_low_reg};
	assign divisor_latch_access_bit = line_control_reg[`LCR_DIVISOR_LATCH_ACCESS_BIT];
	assign wr_acc = psel && penable && pready_reg && pwrite;
	assign rd_acc = psel && penable && pready_reg && !pwrite;
	assign fifo_en = fifo_control_reg[`FCR_EN];
	assign prog_tx_empty_mode_bit_active = interrupt_enable_reg[`IER_PROG_TX_EMPTY_MODE_BIT] && fifo_en;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_control_reg <= `LCR_RESET;
			interrupt_enable_reg <= `IER_RESET;
			fifo_control_reg <= `FCR_RESET;
			modem_control_reg <= `MCR_RESET;
			divisor_low_reg <= `DIV_RESET;
			divisor_high_reg <= `DIV_RESET;
			clock_gate_reg <= `CLKG_RESET;
		end else if (wr_acc) begin
			unique case (paddr)
				`OFS_DATA: if (divisor_latch_access_bit) divisor_low_reg <= pwdata[7:0];
				`OFS_IER: begin
					if (divisor_latch_access_bit) begin
						divisor_high_reg <= pwdata[7:0];
					end else begin
						interrupt_enable_reg <= {pwdata[7], 4'h0, pwdata[2:0]};
					end
				end
				`OFS_IIR: fifo_control_reg <= {pwdata[7:4], 3'h0, pwdata[0]};
				`OFS_LCR: line_control_reg <= pwdata[7:0];
				`OFS_MCR: modem_control_reg <= pwdata[4:0];
				`OFS_CLKG: clock_gate_reg <= pwdata[0];
				default: ;
			endcase
		end
	end

	// Setup-phase decode; answer in the following access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= psel && !penable;
			if (psel && !penable) begin
				prdata_reg <= pwrite ? 32'h0000_0000 : rdata_c;
				pslverr_reg <= !hit_c;
			end else begin
				pslverr_reg <= 1'b0;
			end
		end
	end

	always_comb begin
		rdata_c = 32'h0000_0000;
		hit_c = 1'b1;
		unique case (paddr)
			`OFS_DATA: rdata_c[7:0] = divisor_latch_access_bit ? divisor_low_reg : rx_head;
			`OFS_IER: rdata_c[7:0] = divisor_latch_access_bit ? divisor_high_reg : interrupt_enable_reg;
			`OFS_IIR: rdata_c[7:0] = interrupt_ident_reg;
			`OFS_LCR: rdata_c[7:0] = line_control_reg;
			`OFS_MCR: rdata_c[4:0] = modem_control_reg;
			`OFS_LSR: rdata_c[7:0] = line_status_reg;
			`OFS_USR: rdata_c[0] = busy;
			`OFS_CLKG: rdata_c[0] = clock_gate_reg;
			default: hit_c = 1'b0;
		endcase
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign sys_clk_en = clock_gate_reg;
	assign serial_clk_en = clock_gate_reg;

	// ----------------------------------------
	// FIFOs and holding registers
	// ----------------------------------------
	assign tx_clear = wr_acc && (paddr == `OFS_IIR) && (pwdata[`FCR_TXRST] || (pwdata[`FCR_EN] != fifo_en));
	assign rx_clear = wr_acc && (paddr == `OFS_IIR) && (pwdata[`FCR_RXRST] || (pwdata[`FCR_EN] != fifo_en));
	assign tx_empty = (tx_count == '0);
	assign rx_empty = (rx_count == '0);
	assign tx_full = fifo_en ? (tx_count == DEPTH_C) : !tx_empty;
	assign rx_full = fifo_en ? (rx_count == DEPTH_C) : !rx_empty;
	assign tx_push = wr_acc && (paddr == `OFS_DATA) && !divisor_latch_access_bit && !tx_full;
	assign rx_pop = rd_acc && (paddr == `OFS_DATA) && !divisor_latch_access_bit;
	assign lsr_read = rd_acc && (paddr == `OFS_LSR);

	uart_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk(pclk), .rst_n(presetn), .clear(tx_clear), .push(tx_push), .push_data(pwdata[7:0]),
		.pop(tx_pop), .pop_data(tx_head), .count(tx_count)
	);
	uart_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
		.clk(pclk), .rst_n(presetn), .clear(rx_clear), .push(rx_push && !rx_full), .push_data(rx_word),
		.pop(rx_pop), .pop_data(rx_head), .count(rx_count)
	);

	// ----------------------------------------
	// Baud tick generator
	// ----------------------------------------
	logic [15:0] div_cnt_reg;
	logic baud_tick_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= 16'h0000;
			baud_tick_reg <= 1'b0;
		end else if (divisor == 16'h0000 || !clock_gate_reg) begin
			div_cnt_reg <= 16'h0000;
			baud_tick_reg <= 1'b0;
		end else if (div_cnt_reg == 16'h0000) begin
			div_cnt_reg <= divisor - 16'h0001;
			baud_tick_reg <= 1'b1;
		end else begin
			div_cnt_reg <= div_cnt_reg - 16'h0001;
			baud_tick_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	uart_pkg::tx_state_type tx_state_reg;
	logic [7:0] tx_shift_reg;
	logic [4:0] tx_tcnt_reg;
	logic [2:0] tx_bit_reg;
	logic tx_par_reg;
	logic [2:0] last_bit;
	logic [7:0] len_mask;
	logic [5:0] stop_ticks, tx_limit;

	assign last_bit = {1'b1, line_control_reg[1:0]};
	assign len_mask = 8'hFF >> (2'd3 - line_control_reg[1:0]);
	always_comb begin
		stop_ticks = {1'b0, `BIT_TICKS};
		if (line_control_reg[`LCR_STOP]) begin
			stop_ticks = (line_control_reg[1:0] == 2'b00) ? {1'b0, `BIT_TICKS} + {1'b0, `HALF_TICKS} :
				{1'b0, `BIT_TICKS} + {1'b0, `BIT_TICKS};
		end
	end
	assign tx_limit = (tx_state_reg == uart_pkg::TX_STOP) ? stop_ticks : {1'b0, `BIT_TICKS};
	assign tx_pop = baud_tick_reg && (tx_state_reg == uart_pkg::TX_IDLE) && !tx_empty;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_reg <= uart_pkg::TX_IDLE;
			tx_shift_reg <= 8'h00;
			tx_tcnt_reg <= 5'd0;
			tx_bit_reg <= 3'd0;
			tx_par_reg <= 1'b0;
		end else if (tx_clear) begin
			tx_state_reg <= uart_pkg::TX_IDLE;
			tx_tcnt_reg <= 5'd0;
		end else if (baud_tick_reg) begin
			if (tx_state_reg == uart_pkg::TX_IDLE) begin
				if (!tx_empty) begin
					tx_state_reg <= uart_pkg::TX_START;
					tx_shift_reg <= tx_head;
					tx_par_reg <= (^(tx_head & len_mask)) ^ !line_control_reg[`LCR_EPS];
					tx_tcnt_reg <= 5'd0;
				end
			end else if ({1'b0, tx_tcnt_reg} != tx_limit - 6'd1) begin
				tx_tcnt_reg <= tx_tcnt_reg + 5'd1;
			end else begin
				tx_tcnt_reg <= 5'd0;
				unique case (tx_state_reg)
					uart_pkg::TX_START: begin
						tx_state_reg <= uart_pkg::TX_DATA;
						tx_bit_reg <= 3'd0;
					end
					uart_pkg::TX_DATA: begin
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
						tx_bit_reg <= tx_bit_reg + 3'd1;
						if (tx_bit_reg == last_bit) begin
							tx_state_reg <= line_control_reg[`LCR_PEN] ? uart_pkg::TX_PARITY : uart_pkg::TX_STOP;
						end
					end
					uart_pkg::TX_PARITY: tx_state_reg <= uart_pkg::TX_STOP;
					uart_pkg::TX_STOP: tx_state_reg <= uart_pkg::TX_IDLE;
					default: tx_state_reg <= uart_pkg::TX_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd_reg <= 1'b1;
		end else if (line_control_reg[`LCR_BREAK]) begin
			txd_reg <= 1'b0;
		end else begin
			unique case (tx_state_reg)
				uart_pkg::TX_START: txd_reg <= 1'b0;
				uart_pkg::TX_DATA: txd_reg <= tx_shift_reg[0];
				uart_pkg::TX_PARITY: txd_reg <= tx_par_reg;
				default: txd_reg <= 1'b1;
			endcase
		end
	end
	assign txd = txd_reg;

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	uart_pkg::rx_state_type rx_state_reg;
	logic [7:0] rx_shift_reg;
	logic [4:0] rx_tcnt_reg;
	logic [2:0] rx_bit_reg;
	logic rx_par_reg;
	logic rx_end, rx_par_bad, rx_brk;

	assign rx_end = baud_tick_reg && (rx_tcnt_reg == `BIT_TICKS - 5'd1);
	assign rx_word = rx_shift_reg >> (2'd3 - line_control_reg[1:0]);
	assign rx_par_bad = line_control_reg[`LCR_PEN] &&
		((^rx_word) ^ rx_par_reg ^ !line_control_reg[`LCR_EPS]);
	assign rx_brk = (rx_word == 8'h00) && !rxd && !(line_control_reg[`LCR_PEN] && rx_par_reg);
	assign rx_push = rx_end && (rx_state_reg == uart_pkg::RX_STOP);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state_reg <= uart_pkg::RX_IDLE;
			rx_shift_reg <= 8'h00;
			rx_tcnt_reg <= 5'd0;
			rx_bit_reg <= 3'd0;
			rx_par_reg <= 1'b0;
		end else if (baud_tick_reg) begin
			rx_tcnt_reg <= rx_tcnt_reg + 5'd1;
			unique case (rx_state_reg)
				uart_pkg::RX_IDLE: begin
					rx_tcnt_reg <= 5'd0;
					if (!rxd) rx_state_reg <= uart_pkg::RX_START;
				end
				uart_pkg::RX_START: begin
					if (rx_tcnt_reg == `MID_TICK) begin
						rx_tcnt_reg <= 5'd0;
						rx_bit_reg <= 3'd0;
						rx_state_reg <= rxd ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
					end
				end
				uart_pkg::RX_DATA: begin
					if (rx_end) begin
						rx_tcnt_reg <= 5'd0;
						rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
						rx_bit_reg <= rx_bit_reg + 3'd1;
						if (rx_bit_reg == last_bit) begin
							rx_state_reg <= line_control_reg[`LCR_PEN] ? uart_pkg::RX_PARITY : uart_pkg::RX_STOP;
						end
					end
				end
				uart_pkg::RX_PARITY: begin
					if (rx_end) begin
						rx_tcnt_reg <= 5'd0;
						rx_par_reg <= rxd;
						rx_state_reg <= uart_pkg::RX_STOP;
					end
				end
				uart_pkg::RX_STOP: if (rx_end) rx_state_reg <= uart_pkg::RX_IDLE;
				default: rx_state_reg <= uart_pkg::RX_IDLE;
			endcase
		end
	end

	// Sticky line errors; a new error beats the clearing read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_reg <= 1'b0;
			pe_reg <= 1'b0;
			fe_reg <= 1'b0;
			bi_reg <= 1'b0;
		end else begin
			oe_reg <= (rx_push && rx_full) || (oe_reg && !lsr_read);
			pe_reg <= (rx_push && rx_par_bad) || (pe_reg && !lsr_read);
			fe_reg <= (rx_push && !rxd) || (fe_reg && !lsr_read);
			bi_reg <= (rx_push && rx_brk) || (bi_reg && !lsr_read);
		end
	end

	// ----------------------------------------
	// Status and interrupt identity
	// ----------------------------------------
	always_comb begin
		unique case (fifo_control_reg[5:4])
			2'b00: tx_empty_trigger = '0;
			2'b01: tx_empty_trigger = TET_2;
			2'b10: tx_empty_trigger = LVL_QUARTER;
			default: tx_empty_trigger = LVL_HALF;
		endcase
		unique case (fifo_control_reg[7:6])
			2'b00: rx_trigger_level = CW'(1);
			2'b01: rx_trigger_level = LVL_QUARTER;
			2'b10: rx_trigger_level = LVL_HALF;
			default: rx_trigger_level = LVL_NEAR_FULL;
		endcase
	end

	assign tx_holding_empty_cond = prog_tx_empty_mode_bit_active ? (tx_count <= tx_empty_trigger) : tx_empty;
	assign rx_avail = fifo_en ? (rx_count >= rx_trigger_level) : !rx_empty;
	assign tx_holding_empty = prog_tx_empty_mode_bit_active ? tx_full : tx_empty;
	assign lsi = interrupt_enable_reg[`IER_RLS] && (oe_reg || pe_reg || fe_reg || bi_reg);
	always_comb begin
		iir_id = `IIR_NONE;
		if (lsi) begin
			iir_id = `IIR_RLS;
		end else if (interrupt_enable_reg[`IER_RDA] && rx_avail) begin
			iir_id = `IIR_RDA;
		end else if (interrupt_enable_reg[`IER_TX_HOLDING_EMPTY] && tx_holding_empty_cond) begin
			iir_id = `IIR_TX_HOLDING_EMPTY;
		end
	end
	assign interrupt_ident_reg = {fifo_en, fifo_en, 2'b00, iir_id};
	assign line_status_reg = {1'b0, tx_empty && (tx_state_reg == uart_pkg::TX_IDLE), tx_holding_empty,
		bi_reg, fe_reg, pe_reg, oe_reg, !rx_empty};
	assign busy = !tx_empty || (tx_state_reg != uart_pkg::TX_IDLE) || (rx_state_reg != uart_pkg::RX_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (iir_id != `IIR_NONE);
		end
	end
	assign irq = irq_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_div_stop;
		(divisor == 16'h0000) [*2] |-> !baud_tick_reg;
	endproperty
	a_div_stop: assert property (p_div_stop) else $error("baud tick with zero divisor");

	property p_start_low;
		(tx_state_reg == uart_pkg::TX_START) |=> !txd_reg;
	endproperty
	a_start_low: assert property (p_start_low) else $error("start bit not low");

	property p_bit_len;
		(tx_state_reg == uart_pkg::TX_DATA) |-> (tx_tcnt_reg < `BIT_TICKS);
	endproperty
	a_bit_len: assert property (p_bit_len) else $error("data bit longer than sixteen ticks");

	property p_half_stop;
		(tx_state_reg == uart_pkg::TX_STOP) && (tx_tcnt_reg > `BIT_TICKS) |-> line_control_reg[`LCR_STOP];
	endproperty
	a_half_stop: assert property (p_half_stop) else $error("long stop without stop select");

	property p_false_start;
		(rx_state_reg == uart_pkg::RX_START) && baud_tick_reg && (rx_tcnt_reg == `MID_TICK) && rxd
			|=> (rx_state_reg == uart_pkg::RX_IDLE);
	endproperty
	a_false_start: assert property (p_false_start) else $error("false start accepted");

	property p_lsr_full;
		prog_tx_empty_mode_bit_active |-> (line_status_reg[5] == tx_full);
	endproperty
	a_lsr_full: assert property (p_lsr_full) else $error("status bit five not full flag");

	property p_fifo_off;
		!fifo_en |-> (line_status_reg[5] == tx_empty) && (tx_holding_empty_cond == tx_empty);
	endproperty
	a_fifo_off: assert property (p_fifo_off) else $error("programmable mode active with fifos off");

	property p_gate;
		wr_acc && (paddr == `OFS_CLKG) |=> (sys_clk_en == $past(pwdata[0])) && (serial_clk_en == sys_clk_en);
	endproperty
	a_gate: assert property (p_gate) else $error("clock gate not updated");

	property p_rda_id;
		!lsi && interrupt_enable_reg[`IER_RDA] && rx_avail |-> (interrupt_ident_reg[3:0] == 4'h4) ##1 irq_reg;
	endproperty
	a_rda_id: assert property (p_rda_id) else $error("receive identity wrong");

	property p_answer;
		psel && !penable |=> pready_reg ##1 !pready_reg;
	endproperty
	a_answer: assert property (p_answer) else $error("bus answer timing wrong");

	c_tx_frame: cover property ((tx_state_reg == uart_pkg::TX_STOP) ##1 (tx_state_reg == uart_pkg::TX_IDLE));
	c_rx_push: cover property (rx_push && !rx_full);
	c_false_start: cover property ((rx_state_reg == uart_pkg::RX_START) ##1 (rx_state_reg == uart_pkg::RX_IDLE));
	c_prog_tx_empty_mode_bit_irq: cover property (prog_tx_empty_mode_bit_active && (iir_id == `IIR_TX_HOLDING_EMPTY) && !tx_empty);
endmodule // uart_top

/* verif/serial_peer.sv */
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT = 32
) (
	input wire logic clk,
	input wire logic from_dut,
	output logic to_dut
);
	initial to_dut = 1'b1;

	task automatic hold(input logic b);
		to_dut <= b;
		repeat (BIT) @(posedge clk);
	endtask

	task automatic send(input logic [7:0] v, input int n, input bit pe, input bit ev);
		@(posedge clk);
		hold(1'b0);
		for (int i = 0; i < n; i++) hold(v[i]);
		if (pe) hold((^(v & 8'((1 << n) - 1))) ^ !ev);
		hold(1'b1);
	endtask

	// Short low pulse, released before the midpoint
	task automatic glitch(input int n);
		@(posedge clk);
		to_dut <= 1'b0;
		repeat (n) @(posedge clk);
		to_dut <= 1'b1;
	endtask

	task automatic recv(input int n, input bit pe, output logic [7:0] v, output logic pb, output logic sb,
		output int len);
		int i;
		i = 0;
		v = 8'h00;
		pb = 1'b0;
		len = 0;
		while (from_dut !== 1'b0 && i < 4000) begin
			@(posedge clk);
			i++;
		end
		while (from_dut === 1'b0 && len < 4 * BIT) begin
			@(posedge clk);
			len++;
		end
		repeat (BIT / 2) @(posedge clk);
		for (int k = 0; k < n; k++) begin
			v[k] = from_dut;
			repeat (BIT) @(posedge clk);
		end
		if (pe) begin
			pb = from_dut;
			repeat (BIT) @(posedge clk);
		end
		sb = from_dut;
	endtask
endmodule // serial_peer

/* verif/tb_async_serial_uart.sv */
`timescale 1ns/1ps
`include "uart_map.svh"
module tb_async_serial_uart;
	localparam int DIV = 2;
	logic pclk, presetn, psel, penable, pwrite, rxd, txd, pready, pslverr, irq, sys_clk_en, serial_clk_en;
	logic [7:0] paddr, v;
	logic [31:0] pwdata, prdata, rd;
	logic err, pb, sb;
	int num_errors, n_tests, len, lo;

	uart_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
		.txd(txd), .irq(irq), .sys_clk_en(sys_clk_en), .serial_clk_en(serial_clk_en));
	serial_peer #(.BIT(16 * DIV)) peer (.clk(pclk), .from_dut(txd), .to_dut(rxd));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task automatic wrap_up;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 64);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 64) begin
			num_errors++;
			wrap_up();
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		apb(1'b0, `OFS_LCR, 0);
		chk(rd, 8'h03);
		apb(1'b0, 8'h40, 0);
		chk({31'h0, err}, 8'h01);
		apb(1'b1, `OFS_CLKG, 8'h01);
		@(posedge pclk);
		chk({30'h0, sys_clk_en, serial_clk_en}, 8'h03);
	endtask

	task automatic t_stopped;
		lo = 0;
		apb(1'b1, `OFS_DATA, 8'h11);
		repeat (200) begin
			@(posedge pclk);
			if (txd !== 1'b1) lo++;
		end
		chk(lo, 0);
		apb(1'b1, `OFS_IIR, 8'h04);
	endtask

	task automatic t_divisor;
		apb(1'b1, `OFS_LCR, 8'h83);
		apb(1'b1, `OFS_DATA, DIV);
		apb(1'b1, `OFS_IER, 0);
		apb(1'b0, `OFS_DATA, 0);
		chk(rd, DIV);
		apb(1'b1, `OFS_LCR, 8'h03);
		apb(1'b1, `OFS_IER, 8'h80);
		apb(1'b0, `OFS_IER, 0);
		chk(rd, 8'h80);
	endtask

	task automatic t_tx;
		fork
			peer.recv(8, 1'b0, v, pb, sb, len);
			apb(1'b1, `OFS_DATA, 8'hA5);
		join
		chk(v, 8'hA5);
		chk(len, 16 * DIV);
		chk(sb, 8'h01);
		apb(1'b0, `OFS_LSR, 0);
		chk({31'h0, rd[5]}, 8'h01);
	endtask

	task automatic t_parity;
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, `OFS_LCR, m ? 8'h1A : 8'h0A);
			fork
				peer.recv(7, 1'b1, v, pb, sb, len);
				apb(1'b1, `OFS_DATA, 8'h55);
			join
			chk(v, 8'h55);
			chk(pb, (^(8'h55 & 8'h7F)) ^ !m);
			chk(sb, 8'h01);
		end
		apb(1'b1, `OFS_LCR, 8'h03);
	endtask

	task automatic t_rx;
		apb(1'b1, `OFS_IER, 8'h01);
		peer.send(8'h3C, 8, 1'b0, 1'b0);
		repeat (4) @(posedge pclk);
		chk(irq, 8'h01);
		apb(1'b0, `OFS_IIR, 0);
		chk(rd, 8'h04);
		apb(1'b0, `OFS_DATA, 0);
		chk(rd, 8'h3C);
		repeat (3) @(posedge pclk);
		chk(irq, 8'h00);
	endtask

	task automatic t_glitch;
		peer.glitch(4);
		repeat (12 * 16 * DIV) @(posedge pclk);
		apb(1'b0, `OFS_LSR, 0);
		chk({31'h0, rd[0]}, 8'h00);
		apb(1'b0, `OFS_USR, 0);
		chk(rd, 0);
	endtask

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		presetn = 1'b0;
		num_errors = 0;
		n_tests = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_stopped();
		t_divisor();
		t_tx();
		t_parity();
		t_rx();
		t_glitch();
		wrap_up();
	end
endmodule // tb_async_serial_uart
